// ===== hdl/gpc_gpio_port.sv
// Purpose: General digital I/O ports with pin-change interrupt grouping.
// Assumes: One clock; registers reached over the processor I/O bus.
// Notes:   Pin drive outputs clear without a clock edge when reset asserts.

`timescale 1ns/10ps
`default_nettype none

module gpc_gpio_port
  import gpc_pkg::*;
#(
  parameter int PORT_COUNT = 4
) (
  input  wire logic                              clock,
  input  wire logic                              rst_n,
  input  wire logic [ADDR_WIDTH-1:0]             ioAddr,
  input  wire logic                              ioWrEn,
  input  wire logic                              ioRdEn,
  input  wire logic [PIN_WIDTH-1:0]              ioWrData,
  input  wire logic                              ioBitOp,
  input  wire logic [2:0]                        ioBitNum,
  output logic      [PIN_WIDTH-1:0]              ioRdData,
  input  wire logic [PORT_COUNT*PIN_WIDTH-1:0]   pinIn,
  output logic      [PORT_COUNT*PIN_WIDTH-1:0]   pinOut,
  output logic      [PORT_COUNT*PIN_WIDTH-1:0]   pinOutEnN,
  output logic      [PORT_COUNT*PIN_WIDTH-1:0]   pullupEn,
  input  wire logic [PORT_COUNT*PIN_WIDTH-1:0]   altEnable,
  input  wire logic [PORT_COUNT*PIN_WIDTH-1:0]   altOut,
  input  wire logic [PORT_COUNT*PIN_WIDTH-1:0]   altDrive,
  input  wire logic                              globalIntEnable,
  input  wire logic [GROUP_COUNT-1:0]            irqAck,
  output logic      [GROUP_COUNT-1:0]            changeFlag,
  output logic      [GROUP_COUNT-1:0]            irqRequest
);

  localparam int PIN_COUNT = PORT_COUNT * PIN_WIDTH;

  // Four groups need 28 pins, and the port addresses must stay below the
  // pin-change control registers.
  if (PORT_COUNT < 4 || PORT_COUNT > 5) begin : gen_check
    $error("PORT_COUNT must be 4 or 5");
  end

  function automatic logic [5:0] portAddr(input int port,
                                          input logic [5:0] offset);
    logic [5:0] base;
    base = 6'(port * 3);
    return base + offset;
  endfunction

  function automatic logic [7:0] mergeBits(input logic [7:0] old,
                                           input logic [7:0] data,
                                           input logic [7:0] mask);
    return (old & ~mask) | (data & mask);
  endfunction

  // Register state.
  logic [PORT_COUNT-1:0][PIN_WIDTH-1:0] direction_reg;
  logic [PORT_COUNT-1:0][PIN_WIDTH-1:0] output_latch_reg;
  logic [GROUP_COUNT-1:0]               change_group_control;
  logic [PIN_WIDTH-1:0]                 group0_pin_mask;
  logic [PIN_WIDTH-1:0]                 group1_pin_mask;
  logic [PIN_WIDTH-1:0]                 group2_pin_mask;
  logic [MASK3_BITS-1:0]                group3_pin_mask;
  logic                                 pullup_global_off;

  // Synchroniser and change detection.
  logic [PIN_COUNT-1:0] syncFirst;
  logic [PIN_COUNT-1:0] syncSecond;
  logic [PIN_COUNT-1:0] syncThird;
  logic [PIN_COUNT-1:0] pin_sample_reg;
  logic [PIN_COUNT-1:0] samplePrev;
  logic [PIN_COUNT-1:0] pinChanged;
  logic [PIN_COUNT-1:0] stageAgree;

  // Write path.
  logic [PIN_WIDTH-1:0]   wrByte;
  logic [PIN_WIDTH-1:0]   wrMask;
  logic [GROUP_COUNT-1:0] groupHit;
  logic [GROUP_COUNT-1:0] flagWriteClear;
  logic [PIN_WIDTH-1:0]   next_rdData;
  logic [PIN_WIDTH-1:0]   ctrlMerged;
  logic [PIN_WIDTH-1:0]   mask3Merged;
  logic [PIN_WIDTH-1:0]   coreMerged;
  logic [PIN_WIDTH-1:0]   clearBits;

  // A bit operation writes only the selected bit, taking its value from
  // data bit 0; a plain write covers the whole byte.
  always_comb begin
    if (ioBitOp) begin
      wrMask = 8'h01 << ioBitNum;
      wrByte = {PIN_WIDTH{ioWrData[0]}};
    end else begin
      wrMask = 8'hFF;
      wrByte = ioWrData;
    end
  end

  // Narrow registers are merged at byte width and then cut to size.
  assign ctrlMerged  = mergeBits({4'h0, change_group_control}, wrByte,
                                 wrMask);
  assign mask3Merged = mergeBits({4'h0, group3_pin_mask}, wrByte, wrMask);
  assign coreMerged  = mergeBits(8'h00, wrByte, wrMask);
  assign clearBits   = wrByte & wrMask;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      direction_reg <= '0;
    end else if (ioWrEn) begin
      for (int k = 0; k < PORT_COUNT; k++) begin
        if (ioAddr == portAddr(k, OFS_DIRECTION)) begin
          direction_reg[k] <= mergeBits(direction_reg[k], wrByte,
                                        wrMask);
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      output_latch_reg <= '0;
    end else if (ioWrEn) begin
      for (int k = 0; k < PORT_COUNT; k++) begin
        if (ioAddr == portAddr(k, OFS_LATCH)) begin
          output_latch_reg[k] <= mergeBits(output_latch_reg[k], wrByte,
                                           wrMask);
        end else if (ioAddr == portAddr(k, OFS_SAMPLE)) begin
          // Ones toggle the latch regardless of direction.
          output_latch_reg[k] <= output_latch_reg[k] ^
                                 (wrByte & wrMask);
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      change_group_control <= RESET_NIBBLE;
      group0_pin_mask      <= RESET_BYTE;
      group1_pin_mask      <= RESET_BYTE;
      group2_pin_mask      <= RESET_BYTE;
      group3_pin_mask      <= RESET_NIBBLE;
      pullup_global_off    <= 1'b0;
    end else if (ioWrEn) begin
      if (ioAddr == ADDR_CHANGE_CTRL) begin
        change_group_control <= ctrlMerged[GROUP_COUNT-1:0];
      end else if (ioAddr == ADDR_MASK0) begin
        group0_pin_mask <= mergeBits(group0_pin_mask, wrByte,
                                     wrMask);
      end else if (ioAddr == ADDR_MASK1) begin
        group1_pin_mask <= mergeBits(group1_pin_mask, wrByte,
                                     wrMask);
      end else if (ioAddr == ADDR_MASK2) begin
        group2_pin_mask <= mergeBits(group2_pin_mask, wrByte,
                                     wrMask);
      end else if (ioAddr == ADDR_MASK3) begin
        group3_pin_mask <= mask3Merged[MASK3_BITS-1:0];
      end else if (ioAddr == ADDR_CORE_CTRL) begin
        pullup_global_off <= coreMerged[PULLUP_OFF_POS];
      end
    end
  end

  // Pins are sampled whatever their direction, so a driven value reads
  // back after the synchroniser delay.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      syncFirst  <= '0;
      syncSecond <= '0;
      syncThird  <= '0;
    end else begin
      syncFirst  <= pinIn;
      syncSecond <= syncFirst;
      syncThird  <= syncSecond;
    end
  end

  assign stageAgree = ~(syncSecond ^ syncThird);

  // The sample only moves once the second and third stages agree.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_sample_reg <= '0;
      samplePrev     <= '0;
    end else begin
      pin_sample_reg <= (pin_sample_reg & ~stageAgree) |
                        (syncThird & stageAgree);
      samplePrev     <= pin_sample_reg;
    end
  end

  assign pinChanged = pin_sample_reg ^ samplePrev;

  // A cleared mask bit or group enable keeps the pin out of its group.
  always_comb begin
    groupHit[0] = change_group_control[0] &
                  (|(pinChanged[7:0] & group0_pin_mask));
    groupHit[1] = change_group_control[1] &
                  (|(pinChanged[15:8] & group1_pin_mask));
    groupHit[2] = change_group_control[2] &
                  (|(pinChanged[23:16] & group2_pin_mask));
    groupHit[3] = change_group_control[3] &
                  (|(pinChanged[27:24] & group3_pin_mask));
  end

  always_comb begin
    if (ioWrEn && ioAddr == ADDR_CHANGE_FLAG) begin
      flagWriteClear = clearBits[GROUP_COUNT-1:0];
    end else begin
      flagWriteClear = '0;
    end
  end

  // A new change wins over a clear arriving in the same cycle.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      changeFlag <= '0;
    end else begin
      changeFlag <= (changeFlag & ~(flagWriteClear | irqAck)) |
                    groupHit;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irqRequest <= '0;
    end else begin
      irqRequest <= changeFlag & change_group_control &
                    {GROUP_COUNT{globalIntEnable}};
    end
  end

  // Pin drivers clear asynchronously so the pins float at once on reset.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pinOut    <= '0;
      pinOutEnN <= '1;
      pullupEn  <= '0;
    end else begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        if (altEnable[i]) begin
          pinOutEnN[i] <= ~altDrive[i];
          pinOut[i]    <= altOut[i];
          pullupEn[i]  <= 1'b0;
        end else begin
          pinOutEnN[i] <= ~direction_reg[i / PIN_WIDTH][i % PIN_WIDTH];
          pinOut[i]    <= output_latch_reg[i / PIN_WIDTH]
                                          [i % PIN_WIDTH];
          pullupEn[i]  <= ~direction_reg[i / PIN_WIDTH][i % PIN_WIDTH] &
                          output_latch_reg[i / PIN_WIDTH][i % PIN_WIDTH] &
                          ~pullup_global_off;
        end
      end
    end
  end

  // Read data; unmapped addresses return zero.
  always_comb begin
    next_rdData = READ_UNMAPPED;
    if (ioAddr == ADDR_CHANGE_CTRL) begin
      next_rdData = {4'h0, change_group_control};
    end else if (ioAddr == ADDR_CHANGE_FLAG) begin
      next_rdData = {4'h0, changeFlag};
    end else if (ioAddr == ADDR_MASK0) begin
      next_rdData = group0_pin_mask;
    end else if (ioAddr == ADDR_MASK1) begin
      next_rdData = group1_pin_mask;
    end else if (ioAddr == ADDR_MASK2) begin
      next_rdData = group2_pin_mask;
    end else if (ioAddr == ADDR_MASK3) begin
      next_rdData = {4'h0, group3_pin_mask};
    end else if (ioAddr == ADDR_CORE_CTRL) begin
      next_rdData = 8'(pullup_global_off) << PULLUP_OFF_POS;
    end else begin
      for (int k = 0; k < PORT_COUNT; k++) begin
        if (ioAddr == portAddr(k, OFS_SAMPLE)) begin
          next_rdData = pin_sample_reg[k*PIN_WIDTH +: PIN_WIDTH];
        end else if (ioAddr == portAddr(k, OFS_DIRECTION)) begin
          next_rdData = direction_reg[k];
        end else if (ioAddr == portAddr(k, OFS_LATCH)) begin
          next_rdData = output_latch_reg[k];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ioRdData <= '0;
    end else if (ioRdEn) begin
      ioRdData <= next_rdData;
    end else begin
      ioRdData <= '0;
    end
  end

endmodule

`default_nettype wire

// ===== common/gpc_pkg.sv
// Purpose: Shared constants for the general I/O port and pin-change block.
// Assumes: Byte-wide processor I/O bus, four ports of eight pins.
// Notes:   Function
// Function
// - Group 0 flag sets when an enabled pin among change inputs 0..7 changes.
// - Group flag, group enable and global enable together request the vector.
// - Flag clears on interrupt acknowledge or on writing one; zero leaves it.
// - Group 3 mask bits 7..4 read zero; bits 3..0 enable inputs 24..27.
// - Inputs 24..27 request only with mask bit and group 3 enable set.
// - Group 2 mask enables inputs 16..23, gated by the group 2 enable.
// - Group 1 mask enables inputs 8..15, gated by the group 1 enable.
// - Group 0 mask enables inputs 0..7, gated by the group 0 enable.
// - A cleared mask bit blocks every request from that pin.
// - Single-bit set or clear leaves the other pins of the port alone.
// - Each port has separate output latch, direction and pin sample registers.
// - Pin sample register is read-only storage; latch and direction read/write.
// - Writing one to a pin sample bit inverts the matching latch bit.
// - Global pull-up disable switches off every pull-up on every port.
// - Direction bit one makes the pin an output, zero an input.
// - Input pin with latch one has pull-up; latch zero or output removes it.
// - Output pin drives high for latch one and low for latch zero.
// - Reset puts every pin into high impedance at once, clock or not.
// - Alternate functions on some pins leave the other pins general-purpose.
// - The latch toggle works whatever the direction bit says.
// - Pin sample passes a synchroniser whatever the direction setting.

package gpc_pkg;

  localparam int PIN_WIDTH   = 8;
  localparam int ADDR_WIDTH  = 6;
  localparam int GROUP_COUNT = 4;
  localparam int MASK3_BITS  = 4;

  // Each port occupies three consecutive addresses from its base.
  localparam logic [5:0] PORT_STRIDE   = 6'h03;
  localparam logic [5:0] OFS_SAMPLE    = 6'h00;
  localparam logic [5:0] OFS_DIRECTION = 6'h01;
  localparam logic [5:0] OFS_LATCH     = 6'h02;

  localparam logic [5:0] ADDR_CHANGE_CTRL = 6'h10;
  localparam logic [5:0] ADDR_CHANGE_FLAG = 6'h11;
  localparam logic [5:0] ADDR_MASK0       = 6'h12;
  localparam logic [5:0] ADDR_MASK1       = 6'h13;
  localparam logic [5:0] ADDR_MASK2       = 6'h14;
  localparam logic [5:0] ADDR_MASK3       = 6'h15;
  localparam logic [5:0] ADDR_CORE_CTRL   = 6'h16;

  localparam int PULLUP_OFF_POS = 4;

  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [3:0] RESET_NIBBLE = 4'h0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

endpackage

// ===== testbench/gpc_gpio_port_props.sv
// Purpose: Concurrent checks on the port block's bus, pins and flags.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Bound to the port block at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module gpc_gpio_port_props
  import gpc_pkg::*;
#(parameter int PORT_COUNT = 4) (
  input wire logic                            clock,
  input wire logic                            rst_n,
  input wire logic [ADDR_WIDTH-1:0]           ioAddr,
  input wire logic                            ioWrEn,
  input wire logic                            ioRdEn,
  input wire logic [PIN_WIDTH-1:0]            ioRdData,
  input wire logic [PORT_COUNT*PIN_WIDTH-1:0] pinIn,
  input wire logic [PORT_COUNT*PIN_WIDTH-1:0] pinOut,
  input wire logic [PORT_COUNT*PIN_WIDTH-1:0] pinOutEnN,
  input wire logic [PORT_COUNT*PIN_WIDTH-1:0] pullupEn,
  input wire logic [PORT_COUNT*PIN_WIDTH-1:0] altEnable,
  input wire logic [PORT_COUNT*PIN_WIDTH-1:0] altOut,
  input wire logic [PORT_COUNT*PIN_WIDTH-1:0] altDrive,
  input wire logic                            globalIntEnable,
  input wire logic [GROUP_COUNT-1:0]          irqAck,
  input wire logic [GROUP_COUNT-1:0]          changeFlag,
  input wire logic [GROUP_COUNT-1:0]          irqRequest
);
  logic [3:0]                        keepQ;
  logic [PORT_COUNT*PIN_WIDTH-1:0]   pinQ;
  logic [3*PORT_COUNT*PIN_WIDTH-1:0] altQ;
  always_ff @(posedge clock) begin
    pinQ <= pinIn;
    altQ <= {altEnable, altOut, altDrive};
  end
  // Flags that nothing clears in this cycle must still stand in the next.
  always_ff @(posedge clock) begin
    if (!rst_n || (ioWrEn && ioAddr == ADDR_CHANGE_FLAG)) begin
      keepQ <= 4'h0;
    end else begin
      keepQ <= changeFlag & ~irqAck;
    end
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);
  for (genvar g = 0; g < GROUP_COUNT; g++) begin : g_grp
    logic [3:0] age;
    logic [7:0] diff;
    assign diff = (pinIn[8*g +: 8] ^ pinQ[8*g +: 8]) &
                  ((g == 3) ? 8'h0F : 8'hFF);
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        age <= 4'hF;
      end else if (diff != 8'h00) begin
        age <= 4'h0;
      end else if (age != 4'hF) begin
        age <= age + 4'h1;
      end
    end
    a_flag_has_cause: assert property (
        $rose(changeFlag[g]) |-> age <= 4'h8)
      else $error("group flag rose without a recent pin change");
  end
  sequence s_mask3_read;
    ioRdEn && ioAddr == ADDR_MASK3;
  endsequence
  sequence s_release;
    !rst_n ##1 rst_n;
  endsequence
  a_mask3_high_zero: assert property (
      s_mask3_read |=> ioRdData[7:4] == 4'h0)
    else $error("reserved mask bits read nonzero");
  a_request_needs_flag: assert property ((irqRequest & ~($past(changeFlag)
      & {4{$past(globalIntEnable)}})) == 4'h0)
    else $error("request without flag and global enable");
  a_reset_pins_float: assert property (disable iff (1'b0)
      !rst_n |-> pinOutEnN == '1 && pullupEn == '0)
    else $error("pins not floating in reset");
  a_reset_leaves_clean: assert property (disable iff (1'b0) s_release
      |-> changeFlag == 4'h0 && irqRequest == 4'h0 && pinOutEnN == '1)
    else $error("state not clean after reset");
  a_pullup_not_driven: assert property ((pullupEn & ~pinOutEnN) == '0)
    else $error("pull-up on a driven pin");
  a_flag_sticky: assert property ((keepQ & ~changeFlag) == 4'h0)
    else $error("flag dropped without a clear");
  a_pins_need_write: assert property (
      ($changed(pinOutEnN) || $changed(pinOut) || $changed(pullupEn))
      |-> $past(ioWrEn) || $past(ioWrEn, 2) || $changed(altQ))
    else $error("pin drive changed without a write or alternate change");
endmodule
bind gpc_gpio_port gpc_gpio_port_props #(.PORT_COUNT(PORT_COUNT)) u_props (
  .clock, .rst_n, .ioAddr, .ioWrEn, .ioRdEn, .ioRdData, .pinIn, .pinOut,
  .pinOutEnN, .pullupEn, .altEnable, .altOut, .altDrive, .globalIntEnable,
  .irqAck, .changeFlag, .irqRequest
);
`default_nettype wire

// ===== testbench/gpc_pad_core_model.sv
// Purpose: Pads and processor core facing the port block.
// Assumes: Each pad has a weak board pull-down when nothing else drives it.
// Notes:   The core runs a group's routine only while ackOn is high.
`timescale 1ns/10ps
`default_nettype none
module gpc_pad_core_model (
  input  wire logic        clock,
  input  wire logic [31:0] pinOut,
  input  wire logic [31:0] pinOutEnN,
  input  wire logic [31:0] pullupEn,
  input  wire logic [31:0] extVal,
  input  wire logic [31:0] extEn,
  input  wire logic [3:0]  irqRequest,
  input  wire logic        ackOn,
  output logic      [31:0] pinIn,
  output logic      [3:0]  irqAck = 4'h0
);
  // A driven pad shows the drive, else outside drive, else the pull level.
  assign pinIn = (~pinOutEnN & pinOut) | (pinOutEnN & extEn & extVal)
               | (pinOutEnN & ~extEn & pullupEn);
  always @(posedge clock) begin
    irqAck <= ackOn ? (irqRequest & ~irqAck) : 4'h0;
  end
endmodule
`default_nettype wire

// ===== testbench/test_gpio_port_with_pin_change_irq.sv
// Purpose: Self-checking bench for the general I/O port block.
// Assumes: Pads and core come from the pad and core model.
// Notes:   Alternate function inputs take over one pin of port 3 for a while.
`timescale 1ns/10ps
`default_nettype none
module test_gpio_port_with_pin_change_irq
  import gpc_pkg::*;
;
  logic                  clock = 1'b0;
  logic                  rst_n = 1'b1;
  logic [ADDR_WIDTH-1:0] ioAddr = '0;
  logic                  ioWrEn = 1'b0;
  logic                  ioRdEn = 1'b0;
  logic [PIN_WIDTH-1:0]  ioWrData = '0;
  logic                  ioBitOp = 1'b0;
  logic [2:0]            ioBitNum = 3'h0;
  logic [PIN_WIDTH-1:0]  ioRdData;
  logic [31:0]           pinIn, pinOut, pinOutEnN, pullupEn;
  logic [31:0]           extVal = '0;
  logic [31:0]           extEn = '1;
  logic [31:0]           altEnable = '0;
  logic [31:0]           altOut = '0;
  logic [31:0]           altDrive = '0;
  logic                  globalIntEnable = 1'b0;
  logic                  ackOn = 1'b0;
  logic [3:0]            irqAck, changeFlag, irqRequest;
  int                    n_fail = 0;
  int                    check_count = 0;
  int                    acks = 0;
  always #50 clock = ~clock;
  gpc_gpio_port #(.PORT_COUNT(4)) dut_u (
    .clock, .rst_n, .ioAddr, .ioWrEn, .ioRdEn, .ioWrData, .ioBitOp,
    .ioBitNum, .ioRdData, .pinIn, .pinOut, .pinOutEnN, .pullupEn,
    .altEnable, .altOut, .altDrive, .globalIntEnable,
    .irqAck, .changeFlag, .irqRequest
  );
  gpc_pad_core_model pad_u (
    .clock, .pinOut, .pinOutEnN, .pullupEn, .extVal, .extEn,
    .irqRequest, .ackOn, .pinIn, .irqAck
  );
  always @(posedge clock) if (irqAck[0] === 1'b1) acks++;
  task automatic give_verdict();
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d,
                    input logic bo = 1'b0, input logic [2:0] n = 3'h0);
    @(negedge clock);
    ioAddr = a;
    ioWrData = d;
    ioBitOp = bo;
    ioBitNum = n;
    ioWrEn = 1'b1;
    @(negedge clock);
    ioWrEn = 1'b0;
    ioBitOp = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e, input string w);
    @(negedge clock);
    ioAddr = a;
    ioRdEn = 1'b1;
    @(negedge clock);
    ioRdEn = 1'b0;
    chk(w, e, ioRdData);
  endtask
  task automatic flagWait(input int g);
    for (int i = 0; i < 10 && changeFlag[g] !== 1'b1; i++)
      @(negedge clock);
    chk("changeFlag", 1'b1, changeFlag[g]);
  endtask
  initial begin
    #1 rst_n = 1'b0;
    cyc(2);
    chk("pinOutEnN", 32'hFFFF_FFFF, pinOutEnN);
    rst_n = 1'b1;
    for (int a = 0; a < 23; a++)
      rd(6'(a), 8'h00, "reset value");
    for (int g = 0; g < 4; g++) begin
      wr(ADDR_MASK0 + 6'(g), 8'hA5 + 8'(g));
      rd(ADDR_MASK0 + 6'(g), (g == 3) ? 8'h08 : 8'hA5 + 8'(g),
         "mask");
    end
    extEn = 32'hFFFF_FFF0;
    wr(OFS_DIRECTION, 8'hF0);
    wr(OFS_LATCH, 8'hA5);
    cyc(2);
    chk("pinOutEnN", 8'h0F, pinOutEnN[7:0]);
    chk("pinOut", 4'hA, pinOut[7:4]);
    chk("pullupEn", 8'h05, pullupEn[7:0]);
    cyc(3);
    rd(OFS_SAMPLE, 8'hA5, "pin sample");
    rd(OFS_DIRECTION, 8'hF0, "direction");
    wr(OFS_SAMPLE, 8'h3C);
    rd(OFS_LATCH, 8'h99, "latch toggle");
    cyc(1);
    chk("pullupEn", 8'h09, pullupEn[7:0]);
    wr(ADDR_CORE_CTRL, 8'h10);
    cyc(2);
    chk("pullupEn", 32'h0000_0000, pullupEn);
    wr(ADDR_CORE_CTRL, 8'h00);
    wr(6'h04, 8'h01, 1'b1, 3'h3);
    wr(6'h05, 8'h01, 1'b1, 3'h5);
    wr(6'h05, 8'h01, 1'b1, 3'h3);
    wr(6'h05, 8'h00, 1'b1, 3'h5);
    rd(6'h05, 8'h08, "bit op latch");
    chk("pinOutEnN", 8'hF7, pinOutEnN[15:8]);
    wr(ADDR_MASK0, 8'h01);
    wr(ADDR_CHANGE_CTRL, 8'h0F);
    globalIntEnable = 1'b1;
    extEn[1] = 1'b1;
    extVal[1] = 1'b1;
    cyc(8);
    chk("changeFlag", 4'h0, changeFlag);
    extEn[0] = 1'b1;
    flagWait(0);
    cyc(1);
    chk("irqRequest", 1'b1, irqRequest[0]);
    wr(ADDR_CHANGE_FLAG, 8'h00);
    rd(ADDR_CHANGE_FLAG, 8'h01, "flag after zero");
    wr(ADDR_CHANGE_FLAG, 8'h01);
    rd(ADDR_CHANGE_FLAG, 8'h00, "flag after one");
    ackOn = 1'b1;
    extVal[0] = 1'b1;
    cyc(10);
    chk("acked flag", 1'b0, changeFlag[0]);
    chk("ack seen", 1'b1, acks != 0);
    ackOn = 1'b0;
    wr(ADDR_CHANGE_CTRL, 8'h07);
    wr(ADDR_MASK3, 8'h01);
    extVal[24] = 1'b1;
    cyc(8);
    chk("changeFlag", 1'b0, changeFlag[3]);
    wr(ADDR_CHANGE_CTRL, 8'h0F);
    extVal[24] = 1'b0;
    flagWait(3);
    globalIntEnable = 1'b0;
    cyc(2);
    chk("irqRequest", 4'h0, irqRequest);
    for (int g = 1; g < 3; g++) begin
      extVal[8*g+1] = 1'b1;
      flagWait(g);
    end
    altEnable[31] = 1'b1;
    altDrive[31] = 1'b1;
    altOut[31] = 1'b1;
    wr(6'h0A, 8'h01, 1'b1, 3'h0);
    cyc(2);
    chk("alt port pins", 8'h7E, pinOutEnN[31:24]);
    chk("alt drive", 1'b1, pinOut[31]);
    altEnable[31] = 1'b0;
    altDrive[31] = 1'b0;
    altOut[31] = 1'b0;
    cyc(2);
    chk("alt released", 8'hFE, pinOutEnN[31:24]);
    rst_n = 1'b0;
    #1 chk("pinOutEnN", 32'hFFFF_FFFF, pinOutEnN);
    cyc(2);
    rst_n = 1'b1;
    rd(OFS_DIRECTION, 8'h00, "direction after reset");
    give_verdict();
  end
  // The sequence needs some 180 cycles; the limit allows over twenty times that.
  initial begin
    #400000;
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
